// ---- rtl/adcfc_regs.vh ----
// Filter configuration register map, field layout and timing constants
`ifndef ADCFC_REGS_VH
`define ADCFC_REGS_VH

// Register addresses, first and last setup
`define FC_ADDR_FIRST 6'h28
`define FC_ADDR_LAST 6'h2F
`define FC_ADDR_HI 3'h5
`define FC_RESET 16'h0500

// Field positions
`define FC_MAP_BIT 15
`define FC_PF_EN_BIT 11
`define FC_PF_SEL_HI 10
`define FC_PF_SEL_LO 8
`define FC_ORDER_HI 6
`define FC_ORDER_LO 5
`define FC_ODR_HI 4
`define FC_ODR_LO 0
`define FC_DECIM_HI 14

// Writable bits in normal mapping; reserved 14:12 and 7 stay zero
`define FC_WMASK 16'h8F7F

// Filter order codes
`define FC_ORDER_SINC5 2'h0
`define FC_ORDER_SINC3 2'h3

// Postfilter select codes
`define FC_PF_27SPS 3'h2
`define FC_PF_25SPS 3'h3
`define FC_PF_20SPS 3'h5
`define FC_PF_16SPS 3'h6

// Postfilter settling times in microseconds, as printed in ms
`define FC_PF_27_SETTLE_US 36700
`define FC_PF_25_SETTLE_US 40000
`define FC_PF_20_SETTLE_US 50000
`define FC_PF_16_SETTLE_US 60000
`define FC_US_PER_S 1000000

// Direct sinc3 decimation factor per rate unit
`define FC_DECIM_FACTOR 32

// Single-channel sinc5 + sinc1 rates in samples per second
`define FC_ODR_FAST_SPS 31250
`define FC_ODR_HALF_SPS 15625
`define FC_ODR_FAST_MAX 5'h04
`define FC_ODR_HALF 5'h06
`define FC_ODR_SHIFT_BASE 5'h05

`endif

// ---- rtl/adcfc_timer.v ----
// Conversion timer counting modulator ticks for one conversion period
`timescale 1ns/1ps
module adcfc_timer (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire restart,
  input wire run,
  input wire [31:0] period,
  output reg done
);

  reg [31:0] count_reg;
  reg [31:0] count_next;
  reg done_next;

  // Next count; wraps and pulses done at the end of a period
  always @* begin
    count_next = count_reg;
    done_next = 1'b0;
    if (restart || !run) begin
      count_next = 32'h00000000;
    end else if (count_reg + 32'h00000001 >= period) begin
      count_next = 32'h00000000;
      done_next = 1'b1;
    end else begin
      count_next = count_reg + 32'h00000001;
    end
  end

  // Count state, frozen while the tick enable is low
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= 32'h00000000;
      done <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      done <= done_next;
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// ---- rtl/adcfc_core.v ----
// Per-setup filter configuration registers and conversion control
//
// Operation
// - Eight 16-bit setup filter registers, consecutive addresses
// - Each register resets to 0x0500
// - Any filter register write aborts current conversion
// - After abort, restart at first sequence channel
// - Bit 15 selects direct sinc3 decimation mapping
// - Direct map rate is modulator rate/(32*low bits)
// - Bits 14:12 and 7 reserved, read-only zero unless bit 15 is set
// - Bit 11 enables postfilter, only with order 00
// - Postfilter 010 27SPS, 011 25SPS settling
// - Postfilter 101 20SPS/50ms, 110 16.67SPS/60ms
// - Order 00 sinc5+sinc1, order 11 sinc3
// - Rate codes 0-4 31250SPS, 6 15625SPS
`timescale 1ns/1ps
`include "adcfc_regs.vh"
module adcfc_core #(
  parameter MOD_HZ = 1000000
) (
  input wire CLK,
  input wire RESET,
  input wire CE,
  input wire WR_EN,
  input wire RD_EN,
  input wire [5:0] ADDR,
  input wire [15:0] WDATA,
  output reg [15:0] RDATA,
  output reg RD_HIT,
  input wire CONV_EN,
  input wire [3:0] LAST_CHANNEL,
  input wire [2:0] SETUP_SEL,
  output reg [3:0] CHANNEL,
  output reg CONV_ABORT,
  output reg CONV_BUSY,
  output wire DATA_READY,
  output reg ACT_MAP,
  output reg [14:0] ACT_DECIM,
  output reg ACT_PF_EN,
  output reg [2:0] ACT_PF_SEL,
  output reg [1:0] ACT_ORDER,
  output reg [4:0] ACT_ODR,
  output reg [31:0] ACT_PERIOD
);

  // Conversion control states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONVERT = 2'h1;
  localparam [1:0] ST_ABORT = 2'h2;

  // Modulator ticks per output word, derived from rates and settling
  localparam [31:0] TICKS_FAST = MOD_HZ / `FC_ODR_FAST_SPS;
  localparam [31:0] TICKS_HALF = MOD_HZ / `FC_ODR_HALF_SPS;
  localparam [31:0] TICKS_PF_27 =
    (MOD_HZ / 1000) * `FC_PF_27_SETTLE_US / (`FC_US_PER_S / 1000);
  localparam [31:0] TICKS_PF_25 =
    (MOD_HZ / 1000) * `FC_PF_25_SETTLE_US / (`FC_US_PER_S / 1000);
  localparam [31:0] TICKS_PF_20 =
    (MOD_HZ / 1000) * `FC_PF_20_SETTLE_US / (`FC_US_PER_S / 1000);
  localparam [31:0] TICKS_PF_16 =
    (MOD_HZ / 1000) * `FC_PF_16_SETTLE_US / (`FC_US_PER_S / 1000);
  localparam [31:0] DECIM_FACTOR = `FC_DECIM_FACTOR;

  // Register file, one word per setup
  reg [15:0] fc_mem_reg [0:7];
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] channel_next;
  reg [15:0] act_word;
  wire wr_hit;
  wire rd_hit;
  wire [2:0] wr_index;
  wire conv_done;
  wire restart;
  integer i;

  // True when an address falls on one of the eight setup registers
  function fc_hit;
    input [5:0] addr;
    begin
      fc_hit = (addr[5:3] == `FC_ADDR_HI);
    end
  endfunction

  // Value stored on a write: reserved bits forced low unless direct map
  function [15:0] fc_store;
    input [15:0] data;
    begin
      if (data[`FC_MAP_BIT]) begin
        fc_store = data;
      end else begin
        fc_store = data & `FC_WMASK;
      end
    end
  endfunction

  // Rate code to ticks for the sinc5 + sinc1 and sinc3 paths
  function [31:0] odr_ticks;
    input [4:0] odr;
    begin
      if (odr <= `FC_ODR_FAST_MAX) begin
        odr_ticks = TICKS_FAST;
      end else if (odr == `FC_ODR_HALF) begin
        odr_ticks = TICKS_HALF;
      end else begin
        odr_ticks = TICKS_FAST << (odr - `FC_ODR_SHIFT_BASE);
      end
    end
  endfunction

  // Postfilter code to ticks; undefined codes fall back to the reset code
  function [31:0] pf_ticks;
    input [2:0] sel;
    begin
      case (sel)
        `FC_PF_27SPS: pf_ticks = TICKS_PF_27;
        `FC_PF_25SPS: pf_ticks = TICKS_PF_25;
        `FC_PF_20SPS: pf_ticks = TICKS_PF_20;
        `FC_PF_16SPS: pf_ticks = TICKS_PF_16;
        default: pf_ticks = TICKS_PF_20;
      endcase
    end
  endfunction

  // Conversion period of one setup word, in modulator ticks
  function [31:0] fc_period;
    input [15:0] word;
    reg [31:0] decim;
    begin
      decim = {17'h00000, word[`FC_DECIM_HI:0]};
      if (decim == 32'h00000000) begin
        decim = 32'h00000001;
      end
      if (word[`FC_MAP_BIT]) begin
        fc_period = DECIM_FACTOR * decim;
      end else if (word[`FC_PF_EN_BIT] &&
          word[`FC_ORDER_HI:`FC_ORDER_LO] == `FC_ORDER_SINC5) begin
        fc_period = pf_ticks(word[`FC_PF_SEL_HI:`FC_PF_SEL_LO]);
      end else begin
        fc_period = odr_ticks(word[`FC_ODR_HI:`FC_ODR_LO]);
      end
    end
  endfunction

  assign wr_hit = WR_EN && fc_hit(ADDR);
  assign rd_hit = RD_EN && fc_hit(ADDR);
  assign wr_index = ADDR[2:0];
  assign restart = (state_reg != ST_CONVERT) || wr_hit;

  // Register writes; every setup word resets to its default
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (i = 0; i < 8; i = i + 1) begin
        fc_mem_reg[i] <= `FC_RESET;
      end
    end else if (CE && wr_hit) begin
      fc_mem_reg[wr_index] <= fc_store(WDATA);
    end
  end

  // Read port; data and hit registered
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 16'h0000;
      RD_HIT <= 1'b0;
    end else if (CE) begin
      RD_HIT <= rd_hit;
      if (rd_hit) begin
        RDATA <= fc_mem_reg[ADDR[2:0]];
      end
    end
  end

  // Conversion control sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (CONV_EN) begin
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (wr_hit) begin
          state_next = ST_ABORT;
        end else if (!CONV_EN) begin
          state_next = ST_IDLE;
        end
      end
      ST_ABORT: begin
        if (CONV_EN) begin
          state_next = ST_CONVERT;
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Channel index; returns to the first channel on abort or idle
  always @* begin
    channel_next = CHANNEL;
    if (state_reg != ST_CONVERT || wr_hit) begin
      channel_next = 4'h0;
    end else if (conv_done) begin
      if (CHANNEL >= LAST_CHANNEL) begin
        channel_next = 4'h0;
      end else begin
        channel_next = CHANNEL + 4'h1;
      end
    end
  end

  // Setup word of the channel being converted
  always @* begin
    act_word = fc_mem_reg[SETUP_SEL];
  end

  // State, channel and abort pulse registers
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      CHANNEL <= 4'h0;
      CONV_ABORT <= 1'b0;
      CONV_BUSY <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      CHANNEL <= channel_next;
      CONV_ABORT <= wr_hit && (state_reg == ST_CONVERT);
      CONV_BUSY <= (state_next == ST_CONVERT);
    end
  end

  // Decoded active setup fields, taken while no conversion runs, on a setup write and at each conversion end
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ACT_MAP <= 1'b0;
      ACT_DECIM <= 15'h0000;
      ACT_PF_EN <= 1'b0;
      ACT_PF_SEL <= 3'h5;
      ACT_ORDER <= 2'h0;
      ACT_ODR <= 5'h00;
      ACT_PERIOD <= 32'h00000001;
    end else if (CE && (restart || conv_done)) begin
      ACT_MAP <= act_word[`FC_MAP_BIT];
      ACT_DECIM <= act_word[`FC_DECIM_HI:0];
      // Postfilter enable, order and rate are ignored while direct mapping is active
      ACT_PF_EN <= act_word[`FC_PF_EN_BIT] && !act_word[`FC_MAP_BIT] &&
        (act_word[`FC_ORDER_HI:`FC_ORDER_LO] == `FC_ORDER_SINC5);
      ACT_PF_SEL <= act_word[`FC_PF_SEL_HI:`FC_PF_SEL_LO];
      if (act_word[`FC_MAP_BIT]) begin
        ACT_ORDER <= `FC_ORDER_SINC3;
        ACT_ODR <= 5'h00;
      end else begin
        ACT_ORDER <= act_word[`FC_ORDER_HI:`FC_ORDER_LO];
        ACT_ODR <= act_word[`FC_ODR_HI:`FC_ODR_LO];
      end
      ACT_PERIOD <= fc_period(act_word);
    end
  end

  // Output word timer for the running conversion
  adcfc_timer u_timer (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .restart(restart),
    .run(state_reg == ST_CONVERT),
    .period(ACT_PERIOD),
    .done(conv_done)
  );

  assign DATA_READY = conv_done && (state_reg == ST_CONVERT);

endmodule

// ---- bench/adcfc_props.sv ----
// Checker for the filter setup registers and conversion control
`timescale 1ns/1ps
module adcfc_props #(
  parameter MOD_HZ = 1000000
) (
  input wire CLK,
  input wire RESET,
  input wire CE,
  input wire WR_EN,
  input wire RD_EN,
  input wire [5:0] ADDR,
  input wire [15:0] RDATA,
  input wire RD_HIT,
  input wire [3:0] CHANNEL,
  input wire CONV_ABORT,
  input wire CONV_BUSY,
  input wire DATA_READY,
  input wire ACT_MAP,
  input wire [14:0] ACT_DECIM,
  input wire ACT_PF_EN,
  input wire [2:0] ACT_PF_SEL,
  input wire [1:0] ACT_ORDER,
  input wire [4:0] ACT_ODR,
  input wire [31:0] ACT_PERIOD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Access, abort and decode relations
  a_abort_on_write: assert property (CE && WR_EN && ADDR[5:3] == 3'h5 && CONV_BUSY |=> CONV_ABORT) else $error("no abort");
  a_abort_has_cause: assert property (CONV_ABORT |-> $past(WR_EN && ADDR[5:3] == 3'h5)) else $error("stray abort");
  a_abort_first_chan: assert property (CONV_ABORT |-> CHANNEL == 4'h0) else $error("abort channel");
  a_read_hit_map: assert property (CE |=> RD_HIT == $past(RD_EN && ADDR[5:3] == 3'h5)) else $error("read hit");
  a_rsv_read_zero: assert property (RD_HIT && !RDATA[15] |-> RDATA[14:12] == 3'h0 && !RDATA[7]) else $error("reserved bits");
  a_map_period: assert property (ACT_MAP && ACT_DECIM != 15'h0 |-> ACT_PERIOD == 32 * ACT_DECIM) else $error("map period");
  a_pf_twenty: assert property (!ACT_MAP && ACT_PF_EN && ACT_ORDER == 2'h0 && ACT_PF_SEL == 3'h5 |-> ACT_PERIOD == MOD_HZ / 20) else $error("pf period");
  a_fast_rate: assert property (DATA_READY && !ACT_MAP && !ACT_PF_EN && ACT_ORDER == 2'h0 && ACT_ODR <= 5'h04 |-> ACT_PERIOD == MOD_HZ / 31250) else $error("fast rate");
  a_ready_busy: assert property (DATA_READY |-> CONV_BUSY) else $error("ready idle");
endmodule

// ---- bench/adcfc_core_tb.sv ----
// Testbench for the filter setup registers and conversion control
`timescale 1ns/1ps
module adcfc_core_tb;
  localparam int MOD = 64000;
  logic CLK = 0, RESET = 1, CE = 1, WR_EN = 0, RD_EN = 0, CONV_EN = 0;
  logic [5:0] ADDR = 6'h00;
  logic [15:0] WDATA = 16'h0000, RDATA;
  logic [3:0] LAST_CHANNEL = 4'h2, CHANNEL;
  logic [2:0] SETUP_SEL = 3'h0, ACT_PF_SEL;
  logic RD_HIT, CONV_ABORT, CONV_BUSY, DATA_READY, ACT_MAP, ACT_PF_EN;
  logic [14:0] ACT_DECIM;
  logic [1:0] ACT_ORDER;
  logic [4:0] ACT_ODR;
  logic [31:0] ACT_PERIOD;
  int errors = 0, tests_run = 0, n;
  logic [15:0] wd[7] = '{16'h0A00, 16'h0B00, 16'h0D00, 16'h0E00,
    16'h0000, 16'h0004, 16'h0006};
  int per[7] = '{MOD * 367 / 10000, MOD / 25, MOD / 20, MOD * 6 / 100,
    MOD / 31250, MOD / 31250, MOD / 15625};
  adcfc_core #(.MOD_HZ(MOD)) i_adcfc_core (.*);
  // Clock at 200 MHz
  always #2.5 CLK = ~CLK;
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Strobe accesses; one idle edge first so back-to-back strobes separate
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge CLK);
    #1 WR_EN = 1;
    ADDR = a;
    WDATA = d;
    @(posedge CLK);
    #1 WR_EN = 0;
  endtask
  task rd(input logic [5:0] a, input logic [15:0] e, input logic h);
    @(posedge CLK);
    #1 RD_EN = 1;
    ADDR = a;
    @(posedge CLK);
    #1 RD_EN = 0;
    chk(RD_HIT, h);
    if (h) chk(RDATA, e);
  endtask
  task wait_ready;
    n = 0;
    while (DATA_READY !== 1'b1 && n < 5000) begin
      @(posedge CLK); #1 n++;
    end
    if (n >= 5000) begin
      errors++;
      tally_and_finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge CLK);
    #1 RESET = 0;
    for (int i = 0; i < 8; i++) rd(6'h28 + i[5:0], 16'h0500, 1);
    rd(6'h30, 16'h0000, 0);
    rd(6'h27, 16'h0000, 0);
    wr(6'h2A, 16'h7FFF);
    rd(6'h2A, 16'h0F7F, 1);
    wr(6'h2B, 16'hFFFF);
    rd(6'h2B, 16'hFFFF, 1);
    CONV_EN = 1;
    wr(6'h28, 16'h0001);
    wait_ready;
    @(posedge CLK); #1 chk(CHANNEL, 1);
    wr(6'h28, 16'h8003);
    chk(CONV_ABORT, 1);
    chk(CHANNEL, 0);
    wait_ready;
    chk(ACT_PERIOD, 96);
    chk(n >= 90 && n <= 100, 1);
    chk(CHANNEL, 0);
    for (int i = 0; i < 7; i++) begin
      wr(6'h28, wd[i]);
      repeat (3) @(posedge CLK);
      #1 chk(ACT_PERIOD, per[i]);
      chk(ACT_PF_EN, wd[i][11]);
      chk(ACT_PF_SEL, wd[i][10:8]);
      chk(ACT_ODR, wd[i][4:0]);
    end
    wr(6'h28, 16'h0060);
    repeat (3) @(posedge CLK);
    #1 chk(ACT_ORDER, 2'h3);
    SETUP_SEL = 3'h1;
    wr(6'h29, 16'h8002);
    repeat (3) @(posedge CLK);
    #1 chk(ACT_MAP, 1);
    chk(ACT_PERIOD, 64);
    tally_and_finish;
  end
endmodule
bind adcfc_core adcfc_props #(.MOD_HZ(MOD_HZ)) i_adcfc_props (.*);
